// *** pkg/vrcfg_pkg.sv ***
// Package for the rail 1 configuration register bank.
// Assumes a single 10 MHz clock domain and word-wide PMBus page-0 accesses.
package vrcfg_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_RAIL1_BASIC_CONFIG = 8'he4;
  localparam logic [7:0] CMD_BOOT_VOLTAGE_SETTING = 8'he5;
  localparam logic [7:0] CMD_VOLTAGE_BUS_ADDRESSES = 8'he6;
  localparam logic [7:0] CMD_INPUT_CURRENT_GAIN = 8'he7;
  localparam logic [7:0] CMD_THERMAL_SENSE_CALIBRATION = 8'he8;
  localparam logic [7:0] CMD_PHASE_CURRENT_SENSE_GAIN = 8'he9;
  localparam logic [7:0] CMD_FREQUENCY_LOOP_CONTROL = 8'heb;
  localparam logic [7:0] CMD_SWITCHING_FREQUENCY = 8'hec;
  localparam logic [7:0] CMD_OVERTEMP_PROTECTION_SETTING = 8'hed;

  // ----------------------------------------
  // Writable-bit masks (reserved bits are zero)
  // ----------------------------------------
  localparam logic [15:0] MASK_RAIL1_BASIC_CONFIG = 16'h18ff;
  localparam logic [15:0] MASK_BOOT_VOLTAGE_SETTING = 16'h01ff;
  localparam logic [15:0] MASK_VOLTAGE_BUS_ADDRESSES = 16'h3fff;
  localparam logic [15:0] MASK_INPUT_CURRENT_GAIN = 16'h01ff;
  localparam logic [15:0] MASK_THERMAL_SENSE_CALIBRATION = 16'hffff;
  localparam logic [15:0] MASK_PHASE_CURRENT_SENSE_GAIN = 16'h03ff;
  localparam logic [15:0] MASK_FREQUENCY_LOOP_CONTROL = 16'h7fff;
  localparam logic [15:0] MASK_SWITCHING_FREQUENCY = 16'h01ff;
  localparam logic [15:0] MASK_OVERTEMP_PROTECTION_SETTING = 16'hffff;

  // ----------------------------------------
  // Reset values (none documented; all zero except the bus-address register at 0x0010)
  // ----------------------------------------
  localparam logic [15:0] RST_RAIL1_BASIC_CONFIG = 16'h0000;
  localparam logic [15:0] RST_BOOT_VOLTAGE_SETTING = 16'h0000;
  localparam logic [15:0] RST_VOLTAGE_BUS_ADDRESSES = 16'h0010;
  localparam logic [15:0] RST_INPUT_CURRENT_GAIN = 16'h0000;
  localparam logic [15:0] RST_THERMAL_SENSE_CALIBRATION = 16'h0000;
  localparam logic [15:0] RST_PHASE_CURRENT_SENSE_GAIN = 16'h0000;
  localparam logic [15:0] RST_FREQUENCY_LOOP_CONTROL = 16'h0000;
  localparam logic [15:0] RST_SWITCHING_FREQUENCY = 16'h0000;
  localparam logic [15:0] RST_OVERTEMP_PROTECTION_SETTING = 16'h0000;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_BALANCE_LOOP_ENABLE = 7;
  localparam int BIT_OVERSHOOT_CUT_ENABLE = 6;
  localparam int POS_SHEDDING_SELECT = 4;
  localparam int BIT_HOST_VID_OVERRIDE = 3;
  localparam int POS_FULL_PHASE_NUMBER = 0;
  localparam int POS_FORCED_POWER_STATE = 11;
  localparam int BIT_ALT_VID_TABLE = 8;
  localparam int POS_BOOT_VOLTAGE_CODE = 0;
  localparam int BIT_AVS_EN_RAIL1 = 13;
  localparam int BIT_AVS_EN_RAIL2 = 12;
  localparam int POS_BROADCAST_SELECT = 10;
  localparam int POS_ADDR_OFFSET = 5;
  localparam int BIT_BUS_ADDRESS_SOURCE = 4;
  localparam int POS_RAIL1_BUS_ADDRESS = 0;
  localparam int POS_TEMP_GAIN = 8;
  localparam int POS_TEMP_OFFSET = 0;
  localparam int BIT_HOLD_TRANSIENT = 14;
  localparam int BIT_HOLD_PHASE = 13;
  localparam int BIT_HOLD_VID = 12;
  localparam int POS_HOLD_DURATION = 8;
  localparam int BIT_FREQ_REG_ENABLE = 7;
  localparam int POS_FREQ_KI = 0;
  localparam int POS_OT_LIMIT = 8;
  localparam int BIT_OT_LATCH_MODE = 7;
  localparam int POS_OT_HYST = 0;

  // ----------------------------------------
  // Broadcast addresses and timing
  // ----------------------------------------
  localparam logic [4:0] BROADCAST_ADDR_A = 5'h0e;
  localparam logic [4:0] BROADCAST_ADDR_B = 5'h0f;
  localparam int CLOCK_HZ = 10000000;
  localparam int HOLD_UNIT_US = 100;
  localparam int HOLD_UNIT_CYCLES = (CLOCK_HZ / 1000000) * HOLD_UNIT_US;

  // Power-state encoding of the forced state field.
  typedef enum logic [1:0] {
    VRCFG_PS_FULL = 2'b00,
    VRCFG_PS_ONE_CCM = 2'b01,
    VRCFG_PS_ONE_DCM = 2'b10
  } vrcfg_pstate_t;

endpackage

// *** pkg/vrcfg_if.sv ***
// Interface carrying a frequency-loop hold request between the top and the hold timer.
// Assumes the single system clock.
`timescale 1ns/10ps
interface vrcfg_hold_if;
  logic start;
  logic [3:0] units;
  logic frozen;
  modport ctrl (output start, output units, input frozen);
  modport timer (input start, input units, output frozen);
endinterface

// *** hdl/vrcfg_hold_timer.sv ***
// Frequency-loop freeze timer counting 100 us units.
// Assumes a start pulse from the top; restarts on each new start.
`timescale 1ns/10ps
module vrcfg_hold_timer #(
  parameter int UNIT_CYCLES = vrcfg_pkg::HOLD_UNIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  vrcfg_hold_if.timer hold
);

  logic [10:0] cycle_count;
  logic [3:0] unit_count;

  // ----------------------------------------
  // Countdown
  // ----------------------------------------
  // A restart reloads both counters so the freeze always lasts the full time.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cycle_count <= 11'h000;
      unit_count <= 4'h0;
      hold.frozen <= 1'b0;
    end else if (hold.start) begin
      cycle_count <= 11'(UNIT_CYCLES - 1);
      unit_count <= hold.units;
      hold.frozen <= 1'b1;
    end else if (hold.frozen) begin
      if (cycle_count != 11'h000) begin
        cycle_count <= cycle_count - 11'h001;
      end else if (unit_count > 4'h1) begin
        cycle_count <= 11'(UNIT_CYCLES - 1);
        unit_count <= unit_count - 4'h1;
      end else begin
        hold.frozen <= 1'b0;
      end
    end
  end

endmodule

// *** hdl/vrcfg_overtemp.sv ***
// Over-temperature guard with hiccup or latch recovery.
// Assumes the temperature input is an already-calibrated signed degree value.
`timescale 1ns/10ps
module vrcfg_overtemp (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic signed [9:0] temperature,
  input wire logic [7:0] limit,
  input wire logic [6:0] hysteresis,
  input wire logic latch_mode,
  output logic tripped
);

  logic signed [10:0] release_level;

  // The release level sits a hysteresis below the limit.
  assign release_level = 11'(signed'({3'b000, limit})) - 11'(signed'({4'b0000, hysteresis}));

  // ----------------------------------------
  // Trip state
  // ----------------------------------------
  // Latch mode never releases; only a reset clears it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tripped <= 1'b0;
    end else if (11'(temperature) > 11'(signed'({3'b000, limit}))) begin
      tripped <= 1'b1;
    end else if (tripped && !latch_mode && 11'(temperature) < release_level) begin
      tripped <= 1'b0;
    end
  end

endmodule

// *** hdl/vrcfg_rail1_regs.sv ***
// Rail 1 configuration register bank with its decoded controls.
// Assumes a PMBus engine that presents page-0 word writes and reads as single-cycle strobes.
`timescale 1ns/10ps
module vrcfg_rail1_regs (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [15:0] read_data,
  output logic cmd_known,
  input wire logic [1:0] boot_source,
  input wire logic power_state_force,
  input wire logic load_transient,
  input wire logic phase_count_change,
  input wire logic dynamic_vid_transition,
  input wire logic [7:0] thermal_sense_input,
  input wire logic [11:0] input_current_raw,
  output logic balance_loop_enable,
  output logic overshoot_cut_enable,
  output logic auto_phase_shedding,
  output logic intermediate_vid,
  output logic host_vid_override_enable,
  output logic [2:0] phase_count_active,
  output logic phase_dcm_mode,
  output logic alt_vid_table_enable,
  output logic [7:0] boot_voltage_code,
  output logic boot_from_register,
  output logic avsbus_addr_enable_rail1,
  output logic avsbus_addr_enable_rail2,
  output logic broadcast_addr_a_enable,
  output logic broadcast_addr_b_enable,
  output logic [4:0] rail1_bus_address,
  output logic [4:0] rail2_bus_address,
  output logic [20:0] input_current_scaled,
  output logic [9:0] phase_sense_scale,
  output logic signed [9:0] junction_temperature,
  output logic freq_regulation_enable,
  output logic [6:0] freq_integral_gain,
  output logic freq_loop_frozen,
  output logic [8:0] switch_rate_code,
  output logic overheat_trip
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] rail1_basic_config;
  logic [15:0] boot_voltage_setting;
  logic [15:0] voltage_bus_addresses;
  logic [15:0] input_current_gain;
  logic [15:0] thermal_sense_calibration;
  logic [15:0] phase_current_sense_gain;
  logic [15:0] frequency_loop_control;
  logic [15:0] switching_frequency;
  logic [15:0] overtemp_protection_setting;
  logic [15:0] next_read_data;
  logic hold_event;
  logic [4:0] addr_offset;
  logic [1:0] shedding_select;
  logic [1:0] forced_power_state;
  logic [2:0] full_phase_number;
  logic [17:0] temp_product;
  logic signed [10:0] temp_sum;

  // Hold request goes to the timer; its freeze flag comes back.
  vrcfg_hold_if hold_link ();

  // Tells whether a command code belongs to this bank.
  function automatic logic is_bank_cmd(input logic [7:0] code);
    is_bank_cmd = (code >= vrcfg_pkg::CMD_RAIL1_BASIC_CONFIG && code <= vrcfg_pkg::CMD_PHASE_CURRENT_SENSE_GAIN)
      || (code >= vrcfg_pkg::CMD_FREQUENCY_LOOP_CONTROL && code <= vrcfg_pkg::CMD_OVERTEMP_PROTECTION_SETTING);
  endfunction

  assign cmd_known = is_bank_cmd(cmd_code);

  // Unknown codes fall through and write nothing.
  // Register writes; masking keeps reserved bits at zero.
  // reserved write mask
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rail1_basic_config <= vrcfg_pkg::RST_RAIL1_BASIC_CONFIG;
      boot_voltage_setting <= vrcfg_pkg::RST_BOOT_VOLTAGE_SETTING;
      voltage_bus_addresses <= vrcfg_pkg::RST_VOLTAGE_BUS_ADDRESSES;
      input_current_gain <= vrcfg_pkg::RST_INPUT_CURRENT_GAIN;
      thermal_sense_calibration <= vrcfg_pkg::RST_THERMAL_SENSE_CALIBRATION;
      phase_current_sense_gain <= vrcfg_pkg::RST_PHASE_CURRENT_SENSE_GAIN;
      frequency_loop_control <= vrcfg_pkg::RST_FREQUENCY_LOOP_CONTROL;
      switching_frequency <= vrcfg_pkg::RST_SWITCHING_FREQUENCY;
      overtemp_protection_setting <= vrcfg_pkg::RST_OVERTEMP_PROTECTION_SETTING;
    end else if (write_strobe) begin
      case (cmd_code)
        vrcfg_pkg::CMD_RAIL1_BASIC_CONFIG: begin
          rail1_basic_config <= write_data & vrcfg_pkg::MASK_RAIL1_BASIC_CONFIG;
        end
        vrcfg_pkg::CMD_BOOT_VOLTAGE_SETTING: begin
          boot_voltage_setting <= write_data & vrcfg_pkg::MASK_BOOT_VOLTAGE_SETTING;
        end
        vrcfg_pkg::CMD_VOLTAGE_BUS_ADDRESSES: begin
          voltage_bus_addresses <= write_data & vrcfg_pkg::MASK_VOLTAGE_BUS_ADDRESSES;
        end
        vrcfg_pkg::CMD_INPUT_CURRENT_GAIN: begin
          input_current_gain <= write_data & vrcfg_pkg::MASK_INPUT_CURRENT_GAIN;
        end
        vrcfg_pkg::CMD_THERMAL_SENSE_CALIBRATION: begin
          thermal_sense_calibration <= write_data & vrcfg_pkg::MASK_THERMAL_SENSE_CALIBRATION;
        end
        vrcfg_pkg::CMD_PHASE_CURRENT_SENSE_GAIN: begin
          phase_current_sense_gain <= write_data & vrcfg_pkg::MASK_PHASE_CURRENT_SENSE_GAIN;
        end
        vrcfg_pkg::CMD_FREQUENCY_LOOP_CONTROL: begin
          frequency_loop_control <= write_data & vrcfg_pkg::MASK_FREQUENCY_LOOP_CONTROL;
        end
        vrcfg_pkg::CMD_SWITCHING_FREQUENCY: begin
          switching_frequency <= write_data & vrcfg_pkg::MASK_SWITCHING_FREQUENCY;
        end
        vrcfg_pkg::CMD_OVERTEMP_PROTECTION_SETTING: begin
          overtemp_protection_setting <= write_data & vrcfg_pkg::MASK_OVERTEMP_PROTECTION_SETTING;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unknown codes read zero so the engine can answer without stalling.
  // stored value readback
  always_comb begin
    case (cmd_code)
      vrcfg_pkg::CMD_RAIL1_BASIC_CONFIG: next_read_data = rail1_basic_config;
      vrcfg_pkg::CMD_BOOT_VOLTAGE_SETTING: next_read_data = boot_voltage_setting;
      vrcfg_pkg::CMD_VOLTAGE_BUS_ADDRESSES: next_read_data = voltage_bus_addresses;
      vrcfg_pkg::CMD_INPUT_CURRENT_GAIN: next_read_data = input_current_gain;
      vrcfg_pkg::CMD_THERMAL_SENSE_CALIBRATION: next_read_data = thermal_sense_calibration;
      vrcfg_pkg::CMD_PHASE_CURRENT_SENSE_GAIN: next_read_data = phase_current_sense_gain;
      vrcfg_pkg::CMD_FREQUENCY_LOOP_CONTROL: next_read_data = frequency_loop_control;
      vrcfg_pkg::CMD_SWITCHING_FREQUENCY: next_read_data = switching_frequency;
      vrcfg_pkg::CMD_OVERTEMP_PROTECTION_SETTING: next_read_data = overtemp_protection_setting;
      default: next_read_data = 16'h0000;
    endcase
  end

  // Read data is registered one cycle after the strobe.
  // It holds until the next read strobe.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_data <= 16'h0000;
    end else if (read_strobe) begin
      read_data <= next_read_data;
    end
  end

  // ----------------------------------------
  // Basic configuration decode
  // ----------------------------------------
  assign shedding_select = rail1_basic_config[vrcfg_pkg::POS_SHEDDING_SELECT +: 2];
  assign forced_power_state = rail1_basic_config[vrcfg_pkg::POS_FORCED_POWER_STATE +: 2];
  assign full_phase_number = rail1_basic_config[vrcfg_pkg::POS_FULL_PHASE_NUMBER +: 3];

  // One cycle of lag after a write is harmless here.
  // Loop and mode controls, registered so outputs come from flip-flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      balance_loop_enable <= 1'b0;
      overshoot_cut_enable <= 1'b0;
      auto_phase_shedding <= 1'b0;
      intermediate_vid <= 1'b0;
      host_vid_override_enable <= 1'b0;
    end else begin
      balance_loop_enable <= rail1_basic_config[vrcfg_pkg::BIT_BALANCE_LOOP_ENABLE];
      overshoot_cut_enable <= rail1_basic_config[vrcfg_pkg::BIT_OVERSHOOT_CUT_ENABLE];
      auto_phase_shedding <= shedding_select[1];
      intermediate_vid <= (shedding_select == 2'b01);
      host_vid_override_enable <= rail1_basic_config[vrcfg_pkg::BIT_HOST_VID_OVERRIDE];
    end
  end

  // Forcing enable comes from a pin, not this bank.
  // Phase count: without forcing, the full-phase count applies.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_count_active <= 3'h0;
      phase_dcm_mode <= 1'b1;
    end else if (!power_state_force || forced_power_state == vrcfg_pkg::VRCFG_PS_FULL) begin
      phase_count_active <= full_phase_number;
      phase_dcm_mode <= (full_phase_number == 3'b000);
    end else begin
      phase_count_active <= (forced_power_state == vrcfg_pkg::VRCFG_PS_ONE_CCM) ? 3'b001 : 3'b000;
      phase_dcm_mode <= forced_power_state[1];
    end
  end

  // ----------------------------------------
  // Boot voltage and bus addressing
  // ----------------------------------------
  // Two's complement offset; the sum wraps at 32.
  assign addr_offset = voltage_bus_addresses[vrcfg_pkg::POS_ADDR_OFFSET +: 5];

  // Source bit clear is unsupported: addresses hold.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alt_vid_table_enable <= 1'b0;
      boot_voltage_code <= 8'h00;
      boot_from_register <= 1'b0;
      avsbus_addr_enable_rail1 <= 1'b0;
      avsbus_addr_enable_rail2 <= 1'b0;
      broadcast_addr_a_enable <= 1'b0;
      broadcast_addr_b_enable <= 1'b0;
      rail1_bus_address <= 5'h00;
      rail2_bus_address <= 5'h00;
    end else begin
      alt_vid_table_enable <= boot_voltage_setting[vrcfg_pkg::BIT_ALT_VID_TABLE];
      boot_from_register <= (boot_source == 2'b00);
      boot_voltage_code <= boot_voltage_setting[vrcfg_pkg::POS_BOOT_VOLTAGE_CODE +: 8];
      avsbus_addr_enable_rail1 <= voltage_bus_addresses[vrcfg_pkg::BIT_AVS_EN_RAIL1];
      avsbus_addr_enable_rail2 <= voltage_bus_addresses[vrcfg_pkg::BIT_AVS_EN_RAIL2];
      broadcast_addr_a_enable <= voltage_bus_addresses[vrcfg_pkg::POS_BROADCAST_SELECT];
      broadcast_addr_b_enable <= voltage_bus_addresses[vrcfg_pkg::POS_BROADCAST_SELECT + 1];
      if (voltage_bus_addresses[vrcfg_pkg::BIT_BUS_ADDRESS_SOURCE]) begin
        rail1_bus_address <= {1'b0, voltage_bus_addresses[vrcfg_pkg::POS_RAIL1_BUS_ADDRESS +: 4]};
        rail2_bus_address <= 5'({1'b0, voltage_bus_addresses[3:0]} + addr_offset + 5'h01);
      end
    end
  end

  // ----------------------------------------
  // Sense calibration
  // ----------------------------------------
  // Gain is 0.8 times slope, so the product is divided by 0.8 (times 5/4) then by 256.
  // The sum always fits ten signed bits.
  assign temp_product = 18'(thermal_sense_calibration[vrcfg_pkg::POS_TEMP_GAIN +: 8] * 10'(thermal_sense_input));
  assign temp_sum = 11'(signed'({1'b0, 10'(({2'b00, temp_product} * 20'd5) >> 10)}))
    + 11'(signed'(thermal_sense_calibration[vrcfg_pkg::POS_TEMP_OFFSET +: 8]));

  // Calibrated values are registered.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      input_current_scaled <= 21'h000000;
      phase_sense_scale <= 10'h000;
      junction_temperature <= 10'sh000;
    end else begin
      input_current_scaled <= 21'(input_current_raw * input_current_gain[8:0]);
      phase_sense_scale <= phase_current_sense_gain[9:0];
      junction_temperature <= 10'(temp_sum);
    end
  end

  // ----------------------------------------
  // Frequency loop
  // ----------------------------------------
  // hold event enables
  assign hold_event = (frequency_loop_control[vrcfg_pkg::BIT_HOLD_TRANSIENT] && load_transient)
    || (frequency_loop_control[vrcfg_pkg::BIT_HOLD_PHASE] && phase_count_change)
    || (frequency_loop_control[vrcfg_pkg::BIT_HOLD_VID] && dynamic_vid_transition);
  // Each enabled event restarts the freeze.
  assign hold_link.start = hold_event;
  assign hold_link.units = frequency_loop_control[vrcfg_pkg::POS_HOLD_DURATION +: 4];

  vrcfg_hold_timer u_hold (
    .clock(clock),
    .rst_n(rst_n),
    .hold(hold_link)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      freq_regulation_enable <= 1'b0;
      freq_integral_gain <= 7'h00;
      switch_rate_code <= 9'h000;
    end else begin
      freq_regulation_enable <= frequency_loop_control[vrcfg_pkg::BIT_FREQ_REG_ENABLE];
      freq_integral_gain <= frequency_loop_control[vrcfg_pkg::POS_FREQ_KI +: 7];
      switch_rate_code <= switching_frequency[8:0];
    end
  end

  // The freeze flag covers the start cycle too, so no edge slips through.
  assign freq_loop_frozen = hold_link.frozen || hold_event;

  // ----------------------------------------
  // Over-temperature
  // ----------------------------------------
  // The guard lags the sensor by two cycles: one for calibration, one for the trip flag.
  // trip and recovery
  vrcfg_overtemp u_overtemp (
    .clock(clock),
    .rst_n(rst_n),
    .temperature(junction_temperature),
    .limit(overtemp_protection_setting[vrcfg_pkg::POS_OT_LIMIT +: 8]),
    .hysteresis(overtemp_protection_setting[vrcfg_pkg::POS_OT_HYST +: 7]),
    .latch_mode(overtemp_protection_setting[vrcfg_pkg::BIT_OT_LATCH_MODE]),
    .tripped(overheat_trip)
  );

endmodule

// *** bench/vrcfg_host.sv ***
// Host model issuing page-0 word writes and reads as one-cycle strobes.
// Assumes the bank samples its strobes on the rising clock edge.
`timescale 1ns/10ps
module vrcfg_host (
  input wire logic clock,
  input wire logic [15:0] read_data,
  output logic [7:0] cmd_code,
  output logic [15:0] write_data,
  output logic write_strobe,
  output logic read_strobe
);
  // Idle bus at time zero.
  initial begin
    cmd_code = 8'h00;
    write_data = 16'h0000;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
  end

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clock);
    cmd_code = c;
    write_data = d;
    write_strobe = 1'b1;
    @(negedge clock);
    write_strobe = 1'b0;
    write_data = ~d; // Stale data is inverted so it cannot pass for valid.
  endtask

  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(negedge clock);
    cmd_code = c;
    read_strobe = 1'b1;
    @(negedge clock);
    read_strobe = 1'b0;
    @(negedge clock);
    d = read_data;
  endtask
endmodule

// *** bench/vrcfg_rail1_chk.sv ***
// Checker for the rail 1 register bank, watching its top-level ports.
// Assumes decoded outputs follow a write by two clock edges.
`timescale 1ns/10ps
module vrcfg_rail1_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [15:0] read_data,
  input wire logic cmd_known,
  input wire logic balance_loop_enable,
  input wire logic overshoot_cut_enable,
  input wire logic alt_vid_table_enable,
  input wire logic avsbus_addr_enable_rail1,
  input wire logic [6:0] freq_integral_gain,
  input wire logic [8:0] switch_rate_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // A lone write to command c shows up masked on output o two edges later.
  property p_fld(c, m, o);
    (write_strobe && cmd_code == c) ##1 !write_strobe |-> ##1 o == ($past(write_data, 2) & m);
  endproperty

  AST_KNOWN: assert property (cmd_known == (cmd_code inside {[8'he4:8'he9], [8'heb:8'hed]}))
    else $error("known");
  AST_RSVD: assert property (read_strobe && cmd_code == 8'he5 |=> read_data[15:9] == 7'h00)
    else $error("rsvd");
  AST_BAL: assert property (p_fld(8'he4, 16'h0080, {8'h00, balance_loop_enable, 7'h00})) else $error("bal");
  AST_OSR: assert property (p_fld(8'he4, 16'h0040, {9'h000, overshoot_cut_enable, 6'h00})) else $error("osr");
  AST_ALT: assert property (p_fld(8'he5, 16'h0100, {7'h00, alt_vid_table_enable, 8'h00})) else $error("alt");
  AST_AVS: assert property (p_fld(8'he6, 16'h2000, {2'h0, avsbus_addr_enable_rail1, 13'h0}))
    else $error("avs");
  AST_KI: assert property (p_fld(8'heb, 16'h007f, {9'h000, freq_integral_gain})) else $error("ki");
  AST_FS: assert property (p_fld(8'hec, 16'h01ff, {7'h00, switch_rate_code})) else $error("fs");
  cover property (write_strobe && cmd_code == 8'he4);
  cover property (read_strobe && !cmd_known);
  cover property (read_strobe && cmd_code == 8'he5);
endmodule
bind vrcfg_rail1_regs vrcfg_rail1_chk vrcfg_rail1_chk_inst (.*);

// *** bench/tb_top.sv ***
// Self-checking bench for the rail 1 register bank.
// Assumes the host model and the checker bound to the bank.
`timescale 1ns/10ps
module tb_top;
  logic clock = 0, rst_n = 0, write_strobe, read_strobe, cmd_known, load_transient = 0, power_state_force = 0;
  logic [7:0] cmd_code, thermal_sense_input = 8'h80, boot_voltage_code;
  logic [15:0] write_data, read_data, d;
  logic [1:0] boot_source = 2'b00;
  logic phase_count_change = 0, dynamic_vid_transition = 0, phase_dcm_mode, boot_from_register;
  logic [11:0] input_current_raw = 12'h123;
  logic balance_loop_enable, overshoot_cut_enable, auto_phase_shedding, intermediate_vid, host_vid_override_enable;
  logic alt_vid_table_enable, avsbus_addr_enable_rail1, avsbus_addr_enable_rail2, freq_regulation_enable;
  logic broadcast_addr_a_enable, broadcast_addr_b_enable, freq_loop_frozen, overheat_trip;
  logic [2:0] phase_count_active;
  logic [4:0] rail1_bus_address, rail2_bus_address;
  logic [20:0] input_current_scaled;
  logic [9:0] phase_sense_scale;
  logic signed [9:0] junction_temperature;
  logic [6:0] freq_integral_gain;
  logic [8:0] switch_rate_code;
  int failures = 0, checks = 0;
  vrcfg_rail1_regs vrcfg_rail1_regs_inst (.*);
  vrcfg_host vrcfg_host_inst (.*);
  always #50 clock = ~clock;

  task automatic chk(input logic [20:0] g, input logic [20:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic stop_test();
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Reset values, then all-ones writes read back with reserved bits dropped.
  task automatic t_map();
    logic [7:0] c [9] = '{8'he4, 8'he5, 8'he6, 8'he7, 8'he8, 8'he9, 8'heb, 8'hec, 8'hed};
    logic [15:0] m [9] = '{16'h18ff, 16'h01ff, 16'h3fff, 16'h01ff, 16'hffff, 16'h03ff, 16'h7fff, 16'h01ff, 16'hffff};
    for (int i = 0; i < 9; i++) begin
      vrcfg_host_inst.rd(c[i], d);
      chk(d, (i == 2) ? 16'h0010 : 16'h0000);
      vrcfg_host_inst.wr(c[i], 16'hffff);
      vrcfg_host_inst.rd(c[i], d);
      chk(d, m[i]);
    end
    vrcfg_host_inst.rd(8'hea, d);
    chk(d, 16'h0000);
  endtask

  // Boot code, gains and loop enable follow their registers.
  task automatic t_misc();
    chk(boot_from_register, 1'b1);
    vrcfg_host_inst.wr(8'he5, 16'h005a);
    vrcfg_host_inst.wr(8'he7, 16'h0102);
    vrcfg_host_inst.wr(8'he9, 16'h0155);
    vrcfg_host_inst.wr(8'heb, 16'h0080);
    boot_source = 2'b01;
    repeat (3) @(negedge clock);
    chk(boot_voltage_code, 8'h5a);
    chk(boot_from_register, 1'b0);
    chk(alt_vid_table_enable, 1'b0);
    chk(input_current_scaled, 21'h012546);
    chk(phase_sense_scale, 10'h155);
    chk(freq_regulation_enable, 1'b1);
    boot_source = 2'b00;
  endtask

  // Every shedding code with six phases in full-phase state, then each forced state.
  task automatic t_dec();
    power_state_force = 1'b1;
    for (int s = 0; s < 4; s++) begin
      vrcfg_host_inst.wr(8'he4, {8'h00, 2'b11, 2'(s), s[0], 3'b110});
      repeat (3) @(negedge clock);
      chk(auto_phase_shedding, s[1]);
      chk(intermediate_vid, s == 1);
      chk(phase_count_active, 3'b110);
      chk(phase_dcm_mode, 1'b0);
      chk(host_vid_override_enable, s[0]);
    end
    for (int s = 1; s < 4; s++) begin
      vrcfg_host_inst.wr(8'he4, {3'h0, 2'(s), 11'h006});
      repeat (3) @(negedge clock);
      chk(phase_count_active, s == 1);
      chk(phase_dcm_mode, s > 1);
    end
    power_state_force = 1'b0;
    repeat (2) @(negedge clock);
    chk(phase_count_active, 3'b110);
  endtask

  // Every broadcast code with the most negative rail 2 offset.
  task automatic t_addr();
    for (int s = 0; s < 4; s++) begin
      vrcfg_host_inst.wr(8'he6, 16'h2213 | 16'(s << 10));
      repeat (3) @(negedge clock);
      chk(broadcast_addr_a_enable, s[0]);
      chk(broadcast_addr_b_enable, s[1]);
      chk(rail1_bus_address, 5'h03);
      chk(rail2_bus_address, 5'h14);
      chk(avsbus_addr_enable_rail2, 1'b0);
    end
  endtask

  // Trip at 90 above 80, stay at 78, recover at 70 below 80 minus 5.
  task automatic t_ot();
    logic [15:0] t [3] = '{16'h005a, 16'h004e, 16'h0046};
    vrcfg_host_inst.wr(8'hed, 16'h5005);
    for (int i = 0; i < 3; i++) begin
      vrcfg_host_inst.wr(8'he8, t[i]);
      repeat (4) @(negedge clock);
      chk(junction_temperature, t[i][9:0]);
      chk(overheat_trip, i < 2);
    end
  endtask

  // Only enabled events freeze; a one-unit transient hold lasts about 1000 cycles.
  task automatic t_hold();
    vrcfg_host_inst.wr(8'heb, 16'h4100);
    repeat (3) @(negedge clock);
    chk(freq_regulation_enable, 1'b0);
    {phase_count_change, dynamic_vid_transition} = 2'b11;
    #1 chk(freq_loop_frozen, 1'b0);
    @(negedge clock);
    {phase_count_change, dynamic_vid_transition} = 2'b00;
    load_transient = 1'b1;
    #1 chk(freq_loop_frozen, 1'b1);
    @(negedge clock);
    load_transient = 1'b0;
    repeat (900) @(negedge clock);
    chk(freq_loop_frozen, 1'b1);
    repeat (200) @(negedge clock);
    chk(freq_loop_frozen, 1'b0);
    phase_count_change = 1'b1;
    vrcfg_host_inst.wr(8'heb, 16'h2000);
    #1 chk(freq_loop_frozen, 1'b1);
    phase_count_change = 1'b0;
  endtask

  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    t_map();
    t_misc();
    t_dec();
    t_addr();
    t_ot();
    t_hold();
    stop_test();
  end

  // The tests need some 1300 cycles; 20000 leaves a wide margin.
  initial begin
    #2000000;
    failures++;
    stop_test();
  end
endmodule
